// ===== core/rdc_pkg.sv
// Purpose: Shared constants and types of the divider chain clock
// Assumes: AXI4-Lite with 8-bit byte addresses and 32-bit data
// Notes:   Registers are 16-bit or narrower unless stated
package rdc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] RDC_OFS_CTRL = 8'h00;
	localparam logic [7:0] RDC_OFS_RLD14 = 8'h04;
	localparam logic [7:0] RDC_OFS_CNT14 = 8'h08;
	localparam logic [7:0] RDC_OFS_RLD32 = 8'h0c;
	localparam logic [7:0] RDC_OFS_CNTLO = 8'h10;
	localparam logic [7:0] RDC_OFS_CNTHI = 8'h14;
	localparam logic [7:0] RDC_OFS_IEN = 8'h18;
	localparam logic [7:0] RDC_OFS_IFLG = 8'h1c;

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int RDC_CTRL_RUN = 0;
	localparam int RDC_CTRL_EXTSEL = 1;
	localparam int RDC_CTRL_DIV32 = 2;
	localparam int RDC_CTRL_DIV8 = 3;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [15:0] RDC_RST_RLD14 = 16'h0000;
	localparam logic [31:0] RDC_RST_RLD32 = 32'h0000_0000;
	localparam logic [15:0] RDC_TOP16 = 16'hffff;
	localparam logic [9:0] RDC_TOP10 = 10'h3ff;
	localparam logic [9:0] RDC_TOP6 = 10'h03f;
	localparam logic [4:0] RDC_DIV32_LAST = 5'h1f;
	localparam logic [2:0] RDC_DIV8_LAST = 3'h7;
	localparam logic [1:0] RDC_RESP_OKAY = 2'h0;
	localparam logic [1:0] RDC_RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Bus carriers
	// ----------------------------------------
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} rdcAxiReq_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rdcAxiRsp_t;

	// ----------------------------------------
	// Module state
	// ----------------------------------------
	typedef struct packed {
		logic        run;
		logic        extSel;
		logic        div32En;
		logic        div8En;
		logic [15:0] rld14;
		logic [15:0] cnt14;
		logic [31:0] rld32;
		logic [31:0] cnt32;
		logic [4:0]  ien;
		logic [4:0]  iflg;
		logic [4:0]  div32Cnt;
		logic [2:0]  div8Cnt;
		logic        extPrev;
		logic        awGot;
		logic        wGot;
		logic [7:0]  awAddr;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		rdcAxiRsp_t  rsp;
		logic        irqNode;
	} rdcState_t;

	localparam rdcState_t RDC_STATE_RST = '{
		rld14: RDC_RST_RLD14,
		rld32: RDC_RST_RLD32,
		rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
		default: '0
	};

endpackage : rdc_pkg

// ===== core/rdc_divider_chain.sv
// Purpose: Divider chain clock with AXI4-Lite register access
// Assumes: rst_n is the power reset; pins synchronous to clk
// Notes:   Count halves are read without an atomic latch
// Operation
// - Software picks internal tick or external pin as count source.
// - Divide-by-32 and divide-by-8 prescalers, each switched in or bypassed.
// - 16-bit up timer after prescalers restarts from programmable reload.
// - 32-bit counter of 10, 6, 6, 10-bit reloadable sections, fed by it.
// - Software reads the 32-bit count as low and high halves.
// - Every stage counts upward only.
// - The 16-bit timer and each 32-bit counter section can raise its own interrupt request; the prescalers raise none.
// - Stage requests enabled in IEN merge into one common node request.
// - Only power reset returns registers to reset values.
`timescale 1ns/100ps
module rdc_divider_chain
	import rdc_pkg::*;
(
	// Clock and power reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Count sources
	input  wire logic intTick,
	input  wire logic extClkPin,
	// Register bus
	input  wire rdcAxiReq_t axiReq,
	output rdcAxiRsp_t      axiRsp,
	// Common node request
	output logic            irqNode
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [10:0] bump(input logic [9:0] v,
		input logic [9:0] r, input logic [9:0] top, input logic tk);
		if (!tk) begin
			return {1'b0, v};
		end
		if (v == top) begin
			return {1'b1, r};
		end
		return {1'b0, v + 10'h001};
	endfunction : bump

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return m;
	endfunction : merge

	rdcState_t   st_r;
	rdcState_t   st_nxt;
	logic        srcTick;
	logic        div32Out;
	logic        preTick;
	logic        wrDo;
	logic [4:0]  ovf;
	logic [15:0] cntLow;
	logic [10:0] s0;
	logic [10:0] s1;
	logic [10:0] s2;
	logic [10:0] s3;

	assign cntLow = st_r.cnt32[15:0];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] wd;
		logic [31:0] rd;
		logic        hit;
		wd = '0;
		rd = '0;
		hit = 1'b1;
		st_nxt = st_r;
		st_nxt.extPrev = extClkPin;
		srcTick = st_r.run &&
			(st_r.extSel ? (extClkPin && !st_r.extPrev) : intTick);
		div32Out = st_r.div32En ?
			(srcTick && st_r.div32Cnt == RDC_DIV32_LAST) : srcTick;
		preTick = st_r.div8En ?
			(div32Out && st_r.div8Cnt == RDC_DIV8_LAST) : div32Out;
		if (srcTick && st_r.div32En) begin
			st_nxt.div32Cnt = st_r.div32Cnt + 5'h01;
		end
		if (div32Out && st_r.div8En) begin
			st_nxt.div8Cnt = st_r.div8Cnt + 3'h1;
		end
		ovf[0] = preTick && st_r.cnt14 == RDC_TOP16;
		if (ovf[0]) begin
			st_nxt.cnt14 = st_r.rld14;
		end else if (preTick) begin
			st_nxt.cnt14 = st_r.cnt14 + 16'h0001;
		end
		s0 = bump(st_r.cnt32[9:0], st_r.rld32[9:0], RDC_TOP10, ovf[0]);
		s1 = bump({4'h0, st_r.cnt32[15:10]}, {4'h0, st_r.rld32[15:10]},
			RDC_TOP6, s0[10]);
		s2 = bump({4'h0, st_r.cnt32[21:16]}, {4'h0, st_r.rld32[21:16]},
			RDC_TOP6, s1[10]);
		s3 = bump(st_r.cnt32[31:22], st_r.rld32[31:22], RDC_TOP10, s2[10]);
		ovf[4:1] = {s3[10], s2[10], s1[10], s0[10]};
		st_nxt.cnt32 = {s3[9:0], s2[5:0], s1[5:0], s0[9:0]};
		st_nxt.iflg = st_r.iflg | ovf;
		st_nxt.irqNode = |(st_r.iflg & st_r.ien);
		// Write channel
		if (axiReq.awvalid && st_r.rsp.awready) begin
			st_nxt.awGot = 1'b1;
			st_nxt.awAddr = axiReq.awaddr;
			st_nxt.rsp.awready = 1'b0;
		end
		if (axiReq.wvalid && st_r.rsp.wready) begin
			st_nxt.wGot = 1'b1;
			st_nxt.wData = axiReq.wdata;
			st_nxt.wStrb = axiReq.wstrb;
			st_nxt.rsp.wready = 1'b0;
		end
		wrDo = st_r.awGot && st_r.wGot && !st_r.rsp.bvalid;
		if (wrDo) begin
			st_nxt.awGot = 1'b0;
			st_nxt.wGot = 1'b0;
			st_nxt.rsp.bvalid = 1'b1;
			st_nxt.rsp.bresp = RDC_RESP_OKAY;
			case (st_r.awAddr)
				RDC_OFS_CTRL: begin
					wd = merge({28'h0, st_r.div8En, st_r.div32En,
						st_r.extSel, st_r.run}, st_r.wData, st_r.wStrb);
					st_nxt.run = wd[RDC_CTRL_RUN];
					st_nxt.extSel = wd[RDC_CTRL_EXTSEL];
					st_nxt.div32En = wd[RDC_CTRL_DIV32];
					st_nxt.div8En = wd[RDC_CTRL_DIV8];
				end
				RDC_OFS_RLD14: begin
					wd = merge({16'h0, st_r.rld14}, st_r.wData, st_r.wStrb);
					st_nxt.rld14 = wd[15:0];
				end
				RDC_OFS_CNT14: begin
					wd = merge({16'h0, st_r.cnt14}, st_r.wData, st_r.wStrb);
					st_nxt.cnt14 = wd[15:0];
				end
				RDC_OFS_RLD32: begin
					st_nxt.rld32 = merge(st_r.rld32, st_r.wData, st_r.wStrb);
				end
				RDC_OFS_CNTLO: begin
					wd = merge({16'h0, st_r.cnt32[15:0]}, st_r.wData,
						st_r.wStrb);
					st_nxt.cnt32[15:0] = wd[15:0];
				end
				RDC_OFS_CNTHI: begin
					wd = merge({16'h0, st_r.cnt32[31:16]}, st_r.wData,
						st_r.wStrb);
					st_nxt.cnt32[31:16] = wd[15:0];
				end
				RDC_OFS_IEN: begin
					wd = merge({27'h0, st_r.ien}, st_r.wData, st_r.wStrb);
					st_nxt.ien = wd[4:0];
				end
				RDC_OFS_IFLG: begin
					// write one clears, set still wins
					wd = merge(32'h0, st_r.wData, st_r.wStrb);
					st_nxt.iflg = (st_r.iflg & ~wd[4:0]) | ovf;
				end
				default: begin
					st_nxt.rsp.bresp = RDC_RESP_SLVERR;
				end
			endcase
		end
		if (st_r.rsp.bvalid && axiReq.bready) begin
			st_nxt.rsp.bvalid = 1'b0;
			st_nxt.rsp.awready = 1'b1;
			st_nxt.rsp.wready = 1'b1;
		end
		// Read channel
		if (axiReq.arvalid && st_r.rsp.arready) begin
			case (axiReq.araddr)
				RDC_OFS_CTRL: rd = {28'h0, st_r.div8En, st_r.div32En,
					st_r.extSel, st_r.run};
				RDC_OFS_RLD14: rd = {16'h0, st_r.rld14};
				RDC_OFS_CNT14: rd = {16'h0, st_r.cnt14};
				RDC_OFS_RLD32: rd = st_r.rld32;
				RDC_OFS_CNTLO: rd = {16'h0, st_r.cnt32[15:0]};
				RDC_OFS_CNTHI: rd = {16'h0, st_r.cnt32[31:16]};
				RDC_OFS_IEN: rd = {27'h0, st_r.ien};
				RDC_OFS_IFLG: rd = {27'h0, st_r.iflg};
				default: hit = 1'b0;
			endcase
			st_nxt.rsp.arready = 1'b0;
			st_nxt.rsp.rvalid = 1'b1;
			st_nxt.rsp.rdata = rd;
			st_nxt.rsp.rresp = hit ? RDC_RESP_OKAY : RDC_RESP_SLVERR;
		end
		if (st_r.rsp.rvalid && axiReq.rready) begin
			st_nxt.rsp.rvalid = 1'b0;
			st_nxt.rsp.arready = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// power reset only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= RDC_STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign axiRsp = st_r.rsp;
	assign irqNode = st_r.irqNode;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence prtWrap;
		preTick && st_r.cnt14 == RDC_TOP16 && !wrDo;
	endsequence

	sequence prtStep;
		preTick && st_r.cnt14 != RDC_TOP16 && !wrDo;
	endsequence

	a_ext_source: assert property (
		st_r.run && st_r.extSel && extClkPin && !$past(extClkPin)
		&& $past(st_r.run) |-> srcTick)
		else $error("External edge did not tick the chain");

	a_div_bypass: assert property (
		!st_r.div32En && !st_r.div8En |-> preTick == srcTick)
		else $error("Bypassed prescalers changed the tick");

	a_prt_reload: assert property (
		prtWrap |=> st_r.cnt14 == $past(st_r.rld14))
		else $error("16-bit stage did not reload");

	a_prt_upward: assert property (
		prtStep |=> st_r.cnt14 == $past(st_r.cnt14) + 16'h0001)
		else $error("16-bit stage did not count up");

	a_sec_carry: assert property (
		ovf[1] && !ovf[2] && !wrDo |=>
		st_r.cnt32[15:10] == $past(st_r.cnt32[15:10]) + 6'h01)
		else $error("Carry into second section lost");

	a_low_read: assert property (
		axiReq.arvalid && axiReq.rready && axiRsp.arready
		&& axiReq.araddr == RDC_OFS_CNTLO
		|=> axiRsp.rvalid && axiRsp.rdata[15:0] == $past(cntLow))
		else $error("Low half read wrong");

	a_flag_set: assert property (
		prtWrap |=> st_r.iflg[0] ##1 st_r.iflg[0] || $past(wrDo))
		else $error("Overflow did not set its flag");

	a_flag_sticky: assert property (
		st_r.iflg[0] && !wrDo |=> st_r.iflg[0])
		else $error("Flag dropped without a clear");

	a_node_merge: assert property (
		|(st_r.iflg & st_r.ien) |=> irqNode)
		else $error("Common request missing");

endmodule : rdc_divider_chain

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the divider chain clock
// Assumes: Register map and bus timing as handed over
// Notes:   Expected values follow the counting rules
`timescale 1ns/100ps
module testbench
	import rdc_pkg::*;
;
	logic       clk;
	logic       rst_n;
	logic       intTick;
	logic       extClkPin;
	logic       irqNode;
	rdcAxiReq_t req;
	rdcAxiRsp_t rsp;
	int         numErrors;
	int         samplesChecked;

	rdc_divider_chain dut (
		.clk      (clk),
		.rst_n    (rst_n),
		.intTick  (intTick),
		.extClkPin(extClkPin),
		.axiReq   (req),
		.axiRsp   (rsp),
		.irqNode  (irqNode)
	);

	initial clk = 1'b0;
	always #5 clk = ~clk;

	// ----------------------------------------
	// Verdict and comparison
	// ----------------------------------------
	task reportAndStop;
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : reportAndStop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic overrun(input int n);
		if (n >= 50) begin
			numErrors++;
			reportAndStop();
		end
	endtask : overrun

	// ----------------------------------------
	// Register bus master
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er, input logic [3:0] be = 4'hf);
		int n;
		n = 0;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= be;
		req.bready  <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 50);
		req.bready <= 1'b0;
		overrun(n);
		chk({30'h0, rsp.bresp}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 50);
		req.rready <= 1'b0;
		overrun(n);
		chk(rsp.rdata, e);
		chk({30'h0, rsp.rresp}, {30'h0, er});
	endtask : rd

	// ----------------------------------------
	// Count sources and request line
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			intTick <= 1'b1;
			@(posedge clk);
			intTick <= 1'b0;
		end
	endtask : tick

	task automatic pin(input int n);
		repeat (n) begin
			@(posedge clk);
			extClkPin <= 1'b1;
			repeat (2) @(posedge clk);
			extClkPin <= 1'b0;
			@(posedge clk);
		end
	endtask : pin

	task automatic irq(input logic e);
		repeat (3) @(posedge clk);
		chk({31'h0, irqNode}, {31'h0, e});
	endtask : irq

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		numErrors = 0;
		samplesChecked = 0;
		rst_n = 1'b0;
		intTick = 1'b0;
		extClkPin = 1'b0;
		req = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, RDC_RESP_OKAY);
		irq(1'b0);
		rd(8'h20, 32'h0, RDC_RESP_SLVERR);
		wr(8'h20, 32'hffff_ffff, RDC_RESP_SLVERR);
		wr(RDC_OFS_RLD14, 32'h1234, RDC_RESP_OKAY);
		wr(RDC_OFS_CNT14, 32'hfffe, RDC_RESP_OKAY);
		tick(2);
		rd(RDC_OFS_CNT14, 32'hfffe, RDC_RESP_OKAY);
		wr(RDC_OFS_CTRL, 32'h1, RDC_RESP_OKAY);
		tick(1);
		rd(RDC_OFS_CNT14, 32'hffff, RDC_RESP_OKAY);
		rd(RDC_OFS_IFLG, 32'h0, RDC_RESP_OKAY);
		tick(1);
		rd(RDC_OFS_CNT14, 32'h1234, RDC_RESP_OKAY);
		rd(RDC_OFS_IFLG, 32'h1, RDC_RESP_OKAY);
		rd(RDC_OFS_CNTLO, 32'h1, RDC_RESP_OKAY);
		irq(1'b0);
		wr(RDC_OFS_IEN, 32'h1, RDC_RESP_OKAY);
		irq(1'b1);
		wr(RDC_OFS_IFLG, 32'h0, RDC_RESP_OKAY);
		rd(RDC_OFS_IFLG, 32'h1, RDC_RESP_OKAY);
		wr(RDC_OFS_IFLG, 32'h1, RDC_RESP_OKAY);
		rd(RDC_OFS_IFLG, 32'h0, RDC_RESP_OKAY);
		irq(1'b0);
		wr(RDC_OFS_IEN, 32'h0, RDC_RESP_OKAY);
		wr(RDC_OFS_RLD32, 32'h8081_0805, RDC_RESP_OKAY);
		wr(RDC_OFS_CNTLO, 32'hffff, RDC_RESP_OKAY);
		wr(RDC_OFS_CNTHI, 32'hffff, RDC_RESP_OKAY);
		wr(RDC_OFS_CNT14, 32'hffff, RDC_RESP_OKAY);
		tick(1);
		rd(RDC_OFS_CNTLO, 32'h0805, RDC_RESP_OKAY);
		rd(RDC_OFS_CNTHI, 32'h8081, RDC_RESP_OKAY);
		rd(RDC_OFS_IFLG, 32'h1f, RDC_RESP_OKAY);
		irq(1'b0);
		for (int i = 0; i < 5; i++) begin
			wr(RDC_OFS_IEN, 32'h1 << i, RDC_RESP_OKAY);
			irq(1'b1);
		end
		wr(RDC_OFS_IFLG, 32'h1f, RDC_RESP_OKAY);
		irq(1'b0);
		wr(RDC_OFS_CNTLO, 32'h03ff, RDC_RESP_OKAY);
		wr(RDC_OFS_CNT14, 32'hffff, RDC_RESP_OKAY);
		tick(1);
		rd(RDC_OFS_CNTLO, 32'h0405, RDC_RESP_OKAY);
		rd(RDC_OFS_IFLG, 32'h3, RDC_RESP_OKAY);
		rd(RDC_OFS_RLD32, 32'h8081_0805, RDC_RESP_OKAY);
		wr(RDC_OFS_IFLG, 32'h1f, RDC_RESP_OKAY);
		wr(RDC_OFS_CNT14, 32'h0, RDC_RESP_OKAY);
		wr(RDC_OFS_CTRL, 32'h5, RDC_RESP_OKAY);
		tick(32);
		rd(RDC_OFS_CNT14, 32'h1, RDC_RESP_OKAY);
		wr(RDC_OFS_CTRL, 32'h9, RDC_RESP_OKAY);
		tick(8);
		rd(RDC_OFS_CNT14, 32'h2, RDC_RESP_OKAY);
		wr(RDC_OFS_CTRL, 32'hd, RDC_RESP_OKAY);
		tick(256);
		rd(RDC_OFS_CNT14, 32'h3, RDC_RESP_OKAY);
		wr(RDC_OFS_CNT14, 32'h0, RDC_RESP_OKAY);
		wr(RDC_OFS_CTRL, 32'h3, RDC_RESP_OKAY);
		tick(3);
		pin(4);
		rd(RDC_OFS_CNT14, 32'h4, RDC_RESP_OKAY);
		wr(RDC_OFS_RLD14, 32'h0000_56ff, RDC_RESP_OKAY, 4'h1);
		rd(RDC_OFS_RLD14, 32'h12ff, RDC_RESP_OKAY);
		reportAndStop();
	end
endmodule : testbench
